//--- src/pci_gateway_dev.sv
// Gateway end of the PCI link: arbiter, mastering and pin drive.
// Assumes user side on clk_sys and bus logic on the link clock pciClk.
`timescale 1ns/1ns
module pci_gateway_dev
   import pci_gw_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hostModeStrap,
   input wire logic xferStart,
   input wire logic xferWrite,
   input wire logic [AD_W-1:0] xferAddr,
   input wire logic [LEN_W-1:0] xferLen,
   input wire logic [BURST_MAX*AD_W-1:0] xferWrData,
   output logic xferBusy,
   output logic xferDone,
   output logic [BURST_MAX*AD_W-1:0] xferRdData,
   pci_link_if.device link
);
   logic busy_r;
   logic reqTgl_r;
   logic wrHold_r;
   word_t addrHold_r;
   logic [LEN_W-1:0] lenHold_r;
   burst_t wdHold_r;
   logic doneS1_r;
   logic doneS2_r;
   logic doneSeen_r;
   logic done_r;
   burst_t rdData_r;
   logic doneEdge;
   logic strapS1_r;
   logic strapS2_r;
   logic vld1_r;
   logic vld2_r;
   logic modeLatched_r;
   logic hostMode_r;
   logic reqS1_r;
   logic reqS2_r;
   logic reqSeen_r;
   logic reqEdge;
   logic pending_r;
   logic wrCmd_r;
   word_t addrCmd_r;
   logic [LEN_W-1:0] lenCmd_r;
   word_t wdCmd_r [BURST_MAX];
   word_t rdBuf_r [BURST_MAX];
   mst_state_t state_r;
   mst_state_t state_nxt;
   logic [LEN_W-1:0] cnt_r;
   logic [LEN_W-1:0] cnt_nxt;
   logic granted;
   logic busReqN_r;
   logic doneTgl_r;
   logic [ARB_N-1:0] arbReq;
   logic [ARB_N-1:0] arbGrant;

   // ***********************************************************
   // User side on clk_sys
   // ***********************************************************
   // A start is taken only while idle; the hold registers stay stable
   // until the bus side reports completion.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         busy_r <= 1'b0;
         reqTgl_r <= 1'b0;
         wrHold_r <= 1'b0;
         addrHold_r <= AD_RST;
         lenHold_r <= CNT_RST;
         wdHold_r <= '0;
      end
      else if (xferStart && !busy_r)
      begin
         busy_r <= 1'b1;
         reqTgl_r <= !reqTgl_r;
         wrHold_r <= xferWrite;
         addrHold_r <= xferAddr;
         lenHold_r <= xferLen;
         wdHold_r <= xferWrData;
      end
      else if (doneEdge)
      begin
         busy_r <= 1'b0;
      end
   end

   // Completion toggle crosses back through two flip-flops.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         doneS1_r <= 1'b0;
         doneS2_r <= 1'b0;
         doneSeen_r <= 1'b0;
      end
      else
      begin
         doneS1_r <= doneTgl_r;
         doneS2_r <= doneS1_r;
         doneSeen_r <= doneS2_r;
      end
   end

   assign doneEdge = doneS2_r ^ doneSeen_r;

   // Read words are stable on the bus side once the toggle has moved.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         done_r <= 1'b0;
         rdData_r <= '0;
      end
      else
      begin
         done_r <= doneEdge;
         if (doneEdge)
         begin
            for (int k = 0; k < BURST_MAX; k++)
            begin
               rdData_r[k*AD_W +: AD_W] <= rdBuf_r[k];
            end
         end
      end
   end

   assign xferBusy = busy_r;
   assign xferDone = done_r;
   assign xferRdData = rdData_r;

   // ***********************************************************
   // Mode capture and request crossing on pciClk
   // ***********************************************************
   // The strap is synchronised, then caught once after reset release.
   always_ff @(posedge link.pciClk or negedge link.pciReset_n)
   begin
      if (!link.pciReset_n)
      begin
         strapS1_r <= 1'b0;
         strapS2_r <= 1'b0;
         vld1_r <= 1'b0;
         vld2_r <= 1'b0;
         modeLatched_r <= 1'b0;
         hostMode_r <= 1'b0;
      end
      else
      begin
         strapS1_r <= hostModeStrap;
         strapS2_r <= strapS1_r;
         vld1_r <= 1'b1;
         vld2_r <= vld1_r;
         if (vld2_r && !modeLatched_r)
         begin
            modeLatched_r <= 1'b1;
            hostMode_r <= strapS2_r;
         end
      end
   end

   // Start toggle synchroniser; the command is copied on its edge.
   always_ff @(posedge link.pciClk or negedge link.pciReset_n)
   begin
      if (!link.pciReset_n)
      begin
         reqS1_r <= 1'b0;
         reqS2_r <= 1'b0;
         reqSeen_r <= 1'b0;
         pending_r <= 1'b0;
         wrCmd_r <= 1'b0;
         addrCmd_r <= AD_RST;
         lenCmd_r <= CNT_RST;
         for (int k = 0; k < BURST_MAX; k++)
         begin
            wdCmd_r[k] <= AD_RST;
         end
      end
      else
      begin
         reqS1_r <= reqTgl_r;
         reqS2_r <= reqS1_r;
         reqSeen_r <= reqS2_r;
         if (reqEdge)
         begin
            pending_r <= 1'b1;
            wrCmd_r <= wrHold_r;
            addrCmd_r <= addrHold_r;
            lenCmd_r <= lenHold_r;
            for (int k = 0; k < BURST_MAX; k++)
            begin
               wdCmd_r[k] <= wdHold_r[k*AD_W +: AD_W];
            end
         end
         else if (state_nxt == ST_WAIT)
         begin
            pending_r <= 1'b0;
         end
      end
   end

   assign reqEdge = reqS2_r ^ reqSeen_r;

   // ***********************************************************
   // Arbitration
   // ***********************************************************
   // Only host mode arbitrates; slot zero is this end's own master.
   assign arbReq = (hostMode_r && modeLatched_r) ?
      {!link.request_in_3_n, !link.request_in_2_n, !link.request_in_1_n,
       state_r != ST_IDLE} : GRANT_RST;

   pci_rr_arbiter u_arb
   (
      .clk(link.pciClk),
      .rst_n(link.pciReset_n),
      .req(arbReq),
      .grant_r(arbGrant)
   );

   // Host: one grant per request index. Guest: grant 1 is our request.
   assign link.grant_out_1_n = hostMode_r ? !arbGrant[1] : busReqN_r;
   assign link.grant_out_2_n = hostMode_r ? !arbGrant[2] : LINE_IDLE_N;
   assign link.grant_out_3_n = hostMode_r ? !arbGrant[3] : LINE_IDLE_N;

   assign granted = hostMode_r ? arbGrant[ARB_SELF]
                               : !link.request_in_1_n;

   // ***********************************************************
   // Master sequencer
   // ***********************************************************
   // Address, optional turnaround, then one data phase per word.
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         ST_IDLE:
         begin
            cnt_nxt = CNT_RST;
            if (pending_r && modeLatched_r)
            begin
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            if (granted)
            begin
               state_nxt = ST_ADDR;
            end
         end
         ST_ADDR:
         begin
            state_nxt = wrCmd_r ? ST_DATA : ST_TURN;
         end
         ST_TURN:
         begin
            state_nxt = ST_DATA;
         end
         ST_DATA:
         begin
            if (cnt_r == lenCmd_r)
            begin
               state_nxt = ST_IDLE;
            end
            else
            begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // State and phase counter; all bus inputs sampled on rising edges.
   always_ff @(posedge link.pciClk or negedge link.pciReset_n)
   begin
      if (!link.pciReset_n)
      begin
         state_r <= ST_IDLE;
         cnt_r <= CNT_RST;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Pin drive follows the next state, so pins are registered.
   // No cycle count depends on the bus clock rate.
   always_ff @(posedge link.pciClk or negedge link.pciReset_n)
   begin
      if (!link.pciReset_n)
      begin
         link.devAdOut <= AD_RST;
         link.devAdOe <= 1'b0;
         link.busFrame_n <= LINE_IDLE_N;
         link.busWrite <= 1'b0;
         busReqN_r <= LINE_IDLE_N;
      end
      else
      begin
         link.devAdOut <= (state_nxt == ST_ADDR) ? addrCmd_r
                                                 : wdCmd_r[cnt_nxt];
         link.devAdOe <= (state_nxt == ST_ADDR) ||
            (state_nxt == ST_DATA && wrCmd_r);
         link.busFrame_n <= !(state_nxt == ST_ADDR ||
            state_nxt == ST_TURN ||
            (state_nxt == ST_DATA && cnt_nxt != lenCmd_r));
         link.busWrite <= wrCmd_r && state_nxt != ST_IDLE &&
            state_nxt != ST_WAIT;
         busReqN_r <= (state_nxt == ST_IDLE);
      end
   end

   // Read words are captured each data phase; completion toggles.
   always_ff @(posedge link.pciClk or negedge link.pciReset_n)
   begin
      if (!link.pciReset_n)
      begin
         doneTgl_r <= 1'b0;
         for (int k = 0; k < BURST_MAX; k++)
         begin
            rdBuf_r[k] <= AD_RST;
         end
      end
      else if (state_r == ST_DATA)
      begin
         if (!wrCmd_r)
         begin
            rdBuf_r[cnt_r] <= link.addr_data_bus;
         end
         if (cnt_r == lenCmd_r)
         begin
            doneTgl_r <= !doneTgl_r;
         end
      end
   end
endmodule // pci_gateway_dev

//--- src/pci_gw_pkg.sv
// Shared constants and types for both ends of the PCI arbitration link.
// Assumes both ends and the link interface import this package whole.
package pci_gw_pkg;

   // ***********************************************************
   // Widths and sizes
   // ***********************************************************
   localparam int AD_W = 32;
   localparam int BURST_MAX = 4;
   localparam int LEN_W = 2;
   localparam int ARB_N = 4;
   localparam int IDX_W = 2;
   localparam int ARB_SELF = 0;
   localparam int WORD_LSB = 2;

   // ***********************************************************
   // Values after reset and of undriven lines
   // ***********************************************************
   localparam logic [AD_W-1:0] AD_RST = 32'h00000000;
   localparam logic [AD_W-1:0] AD_PULL = 32'hFFFFFFFF;
   localparam logic LINE_IDLE_N = 1'b1;
   localparam logic [LEN_W-1:0] CNT_RST = 2'h0;
   localparam logic [ARB_N-1:0] GRANT_RST = 4'h0;
   localparam logic [IDX_W-1:0] LAST_RST = 2'h3;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef logic [AD_W-1:0] word_t;
   typedef logic [BURST_MAX*AD_W-1:0] burst_t;
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_WAIT = 5'h02,
      ST_ADDR = 5'h04,
      ST_TURN = 5'h08,
      ST_DATA = 5'h10
   } mst_state_t;

endpackage

//--- src/pci_link_if.sv
// Link between the gateway end and the far end of the PCI bus.
// Assumes the bench supplies the bus clock and the bus reset.
`timescale 1ns/1ns
interface pci_link_if
   import pci_gw_pkg::*;
(
   input wire logic pciClk,
   input wire logic pciReset_n
);
   logic request_in_1_n;
   logic request_in_2_n;
   logic request_in_3_n;
   logic grant_out_1_n;
   logic grant_out_2_n;
   logic grant_out_3_n;
   word_t devAdOut;
   logic devAdOe;
   word_t farAdOut;
   logic farAdOe;
   logic busFrame_n;
   logic busWrite;
   word_t addr_data_bus;

   // The shared lines float high when nobody drives them.
   assign addr_data_bus = devAdOe ? devAdOut : (farAdOe ? farAdOut : AD_PULL);

   modport device
   (
      input pciClk, pciReset_n, request_in_1_n, request_in_2_n,
      input request_in_3_n, addr_data_bus,
      output grant_out_1_n, grant_out_2_n, grant_out_3_n,
      output devAdOut, devAdOe, busFrame_n, busWrite
   );
   modport far
   (
      input pciClk, pciReset_n, grant_out_1_n, grant_out_2_n,
      input grant_out_3_n, addr_data_bus, busFrame_n, busWrite,
      output request_in_1_n, request_in_2_n, request_in_3_n,
      output farAdOut, farAdOe
   );
endinterface

//--- src/pci_rr_arbiter.sv
// Round-robin arbiter with registered one-hot grants.
// Assumes requests are synchronous to clk; a grant holds while requested.
`timescale 1ns/1ns
module pci_rr_arbiter
   import pci_gw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ARB_N-1:0] req,
   output logic [ARB_N-1:0] grant_r
);
   logic [ARB_N-1:0] grant_nxt;
   logic [IDX_W-1:0] last_r;
   logic [IDX_W-1:0] last_nxt;

   // ***********************************************************
   // Selection
   // ***********************************************************
   // The holder keeps the bus; otherwise the nearest after the last wins.
   always_comb
   begin
      int idx;
      idx = 0;
      grant_nxt = grant_r & req;
      last_nxt = last_r;
      if (grant_nxt == GRANT_RST)
      begin
         for (int k = ARB_N; k >= 1; k--)
         begin
            idx = (int'(last_r) + k) % ARB_N;
            if (req[idx])
            begin
               grant_nxt = ARB_N'(1) << idx;
               last_nxt = IDX_W'(idx);
            end
         end
      end
   end

   // Grant and rotation pointer registers.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         grant_r <= GRANT_RST;
         last_r <= LAST_RST;
      end
      else
      begin
         grant_r <= grant_nxt;
         last_r <= last_nxt;
      end
   end
endmodule // pci_rr_arbiter

//--- src/pci_far_end.sv
// Far end of the PCI link: external masters or arbiter, and a target.
// Assumes user-side ports are synchronous to the link clock.
`timescale 1ns/1ns
module pci_far_end
   import pci_gw_pkg::*;
(
   input wire logic farHostMode,
   input wire logic [2:0] extReq,
   output logic [2:0] extGrant,
   pci_link_if.far link
);
   logic request_in_1_n_r;
   logic request_in_2_n_r;
   logic request_in_3_n_r;
   logic active_r;
   logic isWr_r;
   logic turn_r;
   logic [LEN_W-1:0] idx_r;
   logic oe_r;
   word_t out_r;
   word_t mem_r [BURST_MAX];
   logic [2:0] grant_r;

   // ***********************************************************
   // Request lines
   // ***********************************************************
   // Host mode: masters request. Guest mode: request 1 carries our grant,
   // and lines 2 and 3 still follow the masters so the gateway must
   // ignore them as reserved pins.
   always_ff @(posedge link.pciClk or negedge link.pciReset_n)
   begin
      if (!link.pciReset_n)
      begin
         request_in_1_n_r <= LINE_IDLE_N;
         request_in_2_n_r <= LINE_IDLE_N;
         request_in_3_n_r <= LINE_IDLE_N;
         grant_r <= 3'h0;
      end
      else
      begin
         request_in_1_n_r <= farHostMode ? !extReq[0] : link.grant_out_1_n;
         request_in_2_n_r <= !extReq[1];
         request_in_3_n_r <= !extReq[2];
         grant_r <= {!link.grant_out_3_n, !link.grant_out_2_n,
                     !link.grant_out_1_n};
      end
   end

   assign link.request_in_1_n = request_in_1_n_r;
   assign link.request_in_2_n = request_in_2_n_r;
   assign link.request_in_3_n = request_in_3_n_r;
   assign extGrant = farHostMode ? grant_r : 3'h0;

   // ***********************************************************
   // Target
   // ***********************************************************
   // Frame low while idle marks an address phase; frame high in a
   // data phase marks the last one.
   always_ff @(posedge link.pciClk or negedge link.pciReset_n)
   begin
      if (!link.pciReset_n)
      begin
         active_r <= 1'b0;
         isWr_r <= 1'b0;
         turn_r <= 1'b0;
         idx_r <= CNT_RST;
         oe_r <= 1'b0;
         out_r <= AD_RST;
      end
      else if (!active_r && !link.busFrame_n)
      begin
         active_r <= 1'b1;
         isWr_r <= link.busWrite;
         turn_r <= !link.busWrite;
         idx_r <= link.addr_data_bus[WORD_LSB +: LEN_W];
      end
      else if (active_r && turn_r)
      begin
         turn_r <= 1'b0;
         oe_r <= !isWr_r;
         out_r <= mem_r[idx_r];
      end
      else if (active_r)
      begin
         idx_r <= idx_r + 1'b1;
         out_r <= mem_r[LEN_W'(idx_r + 1'b1)];
         if (link.busFrame_n)
         begin
            active_r <= 1'b0;
            oe_r <= 1'b0;
         end
      end
   end

   // Write data phases store into the word memory.
   always_ff @(posedge link.pciClk or negedge link.pciReset_n)
   begin
      if (!link.pciReset_n)
      begin
         for (int k = 0; k < BURST_MAX; k++)
         begin
            mem_r[k] <= AD_RST;
         end
      end
      else if (active_r && !turn_r && isWr_r)
      begin
         mem_r[idx_r] <= link.addr_data_bus;
      end
   end

   assign link.farAdOe = oe_r;
   assign link.farAdOut = out_r;
endmodule // pci_far_end

//--- tb/pci_link_assertions.sv
// Concurrent checks on the shared link between the two PCI ends.
// Assumes the bench connects it by name beside the link interface.
`timescale 1ns/1ns
module pci_link_assertions
   import pci_gw_pkg::*;
(
   input wire logic pciClk,
   input wire logic pciReset_n,
   input wire logic request_in_2_n,
   input wire logic request_in_3_n,
   input wire logic grant_out_1_n,
   input wire logic grant_out_2_n,
   input wire logic grant_out_3_n,
   input wire logic devAdOe,
   input wire logic farAdOe,
   input wire logic busFrame_n,
   input wire logic busWrite,
   input wire word_t addr_data_bus
);
   // ****************************************
   // Sequences and properties
   // ****************************************
   // Every check runs on the bus clock and rests during bus reset.
   default clocking linkCb @(posedge pciClk);
   endclocking
   default disable iff (!pciReset_n);

   // A read opens with the gateway driving the address.
   sequence readAddr;
      $rose(devAdOe) && !busWrite;
   endsequence
   // The turnaround leaves the lines undriven, so they float high.
   sequence turnCycle;
      !devAdOe && !farAdOe && !busFrame_n && addr_data_bus == AD_PULL;
   endsequence
   // The last write data phase has the frame already released.
   sequence lastWrite;
      devAdOe && busWrite && busFrame_n;
   endsequence

   a_grant_one_hot: assert property (
      $onehot0(~{grant_out_3_n, grant_out_2_n, grant_out_1_n}))
      else $error("more than one grant low");
   a_single_driver: assert property (!(devAdOe && farAdOe))
      else $error("both ends drive the lines");
   a_read_turn: assert property (readAddr |=> turnCycle ##1 farAdOe)
      else $error("read turnaround missing");
   a_addr_frame: assert property ($rose(devAdOe) |-> !busFrame_n)
      else $error("address phase without frame");
   a_burst_len: assert property (
      $fell(busFrame_n) |-> ##[1:5] $rose(busFrame_n))
      else $error("frame longer than a full burst");
   a_write_data: assert property (
      $rose(devAdOe) && busWrite |=> devAdOe && busWrite)
      else $error("write data not driven by gateway");
   a_write_release: assert property (lastWrite |=> !devAdOe && !busWrite)
      else $error("lines held after last write");
   a_target_read: assert property (farAdOe |-> !busWrite)
      else $error("target drives during a write");
   a_reset_idle: assert property (
      $rose(pciReset_n) |-> grant_out_1_n && grant_out_2_n &&
         grant_out_3_n && !devAdOe && !farAdOe && busFrame_n)
      else $error("link not idle after reset");
   a_grant2_cause: assert property (!grant_out_2_n |->
      !$past(request_in_2_n) || !$past(request_in_2_n, 2) ||
      !$past(request_in_2_n, 3))
      else $error("grant 2 without request 2");
   a_grant3_cause: assert property (!grant_out_3_n |->
      !$past(request_in_3_n) || !$past(request_in_3_n, 2) ||
      !$past(request_in_3_n, 3))
      else $error("grant 3 without request 3");
endmodule // pci_link_assertions

//--- tb/pci_arbitration_pin_interface_tb_top.sv
// Bench joining the gateway end and the far end through the link.
// Assumes the package, the interface and both ends are compiled first.
`timescale 1ns/1ns
module pci_arbitration_pin_interface_tb_top;
   import pci_gw_pkg::*;
   typedef struct {logic isRead; logic [LEN_W-1:0] len; burst_t data;} note_t;
   logic clk_sys = 1'b0;
   logic pciClk = 1'b0;
   logic resetn = 1'b0;
   logic pciReset_n = 1'b0;
   logic hostModeStrap = 1'b1;
   logic farMode = 1'b1;
   logic xferStart = 1'b0;
   logic xferWrite = 1'b0;
   word_t xferAddr = AD_RST;
   logic [LEN_W-1:0] xferLen = CNT_RST;
   burst_t xferWrData = 128'h0;
   logic xferBusy;
   logic xferDone;
   burst_t xferRdData;
   logic [2:0] extReq = 3'h0;
   logic [2:0] extGrant;
   logic [31:0] rngState = 32'h000066F6;
   note_t noteQ[$];
   note_t curNote;
   int error_cnt = 0;
   int cmp_count = 0;

   // ****************************************
   // Design and checker
   // ****************************************
   pci_link_if pci_link_if_i (.pciClk(pciClk), .pciReset_n(pciReset_n));
   pci_gateway_dev pci_gateway_dev_i (.clk_sys(clk_sys), .resetn(resetn),
      .hostModeStrap(hostModeStrap), .xferStart(xferStart),
      .xferWrite(xferWrite), .xferAddr(xferAddr), .xferLen(xferLen),
      .xferWrData(xferWrData), .xferBusy(xferBusy), .xferDone(xferDone),
      .xferRdData(xferRdData), .link(pci_link_if_i.device));
   pci_far_end pci_far_end_i (.farHostMode(farMode), .extReq(extReq),
      .extGrant(extGrant), .link(pci_link_if_i.far));
   pci_link_assertions pci_link_assertions_i (.pciClk(pciClk),
      .pciReset_n(pciReset_n),
      .request_in_2_n(pci_link_if_i.request_in_2_n),
      .request_in_3_n(pci_link_if_i.request_in_3_n),
      .grant_out_1_n(pci_link_if_i.grant_out_1_n),
      .grant_out_2_n(pci_link_if_i.grant_out_2_n),
      .grant_out_3_n(pci_link_if_i.grant_out_3_n),
      .devAdOe(pci_link_if_i.devAdOe), .farAdOe(pci_link_if_i.farAdOe),
      .busFrame_n(pci_link_if_i.busFrame_n),
      .busWrite(pci_link_if_i.busWrite),
      .addr_data_bus(pci_link_if_i.addr_data_bus));

   // ****************************************
   // Clocks and helpers
   // ****************************************
   // The system clock flips every 5 ns.
   always #5 clk_sys = ~clk_sys;
   // The link clock is offset by 1 ns so its rising edges never meet those of clk_sys.
   initial
   begin
      #1;
      forever #3 pciClk = ~pciClk;
   end

   // Xorshift source for addresses, data and reserved request noise.
   function logic [31:0] rand32();
      rngState = rngState ^ (rngState << 13);
      rngState = rngState ^ (rngState >> 17);
      rngState = rngState ^ (rngState << 5);
      return rngState;
   endfunction

   task fail(input string msg);
      $display("ERROR at %0t: %s", $time, msg);
      error_cnt++;
   endtask

   task complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task cmp_burst(input burst_t got, input burst_t exp,
                  input logic [LEN_W-1:0] len);
      for (int k = 0; k <= int'(len); k++)
      begin
         cmp_count++;
         if (got[k*AD_W +: AD_W] !== exp[k*AD_W +: AD_W])
            fail("read word differs");
      end
   endtask

   task cmp_grant(input logic [2:0] got, input logic [2:0] exp);
      cmp_count++;
      if (got !== exp)
         fail("grant pattern differs");
   endtask

   // Both resets are held 16 system cycles; the bus reset leaves on pciClk.
   task do_reset(input logic host);
      resetn = 1'b0;
      pciReset_n = 1'b0;
      hostModeStrap = host;
      farMode = host;
      repeat (16) @(posedge clk_sys);
      #1 resetn = 1'b1;
      @(posedge pciClk);
      #1 pciReset_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask

   // One transfer: note the expectation, start it, wait until not busy.
   task xfer(input logic wr, input logic [LEN_W-1:0] len,
             input word_t addr, input burst_t data);
      int w;
      noteQ.push_back('{!wr, len, data});
      xferStart = 1'b1;
      xferWrite = wr;
      xferAddr = addr;
      xferLen = len;
      xferWrData = data;
      @(posedge clk_sys);
      #1 xferStart = 1'b0;
      w = 0;
      while (xferBusy !== 1'b0 && w < 2000)
      begin
         @(posedge clk_sys);
         #1 w++;
      end
      if (w >= 2000)
      begin
         fail("transfer hung");
         complete_run();
      end
   endtask

   // A burst write and a read of the same words straight after it.
   task rw_pair(input logic [LEN_W-1:0] len);
      word_t a;
      burst_t d;
      a = rand32() & 32'hFFFFFFFC;
      d = {rand32(), rand32(), rand32(), rand32()};
      xfer(1'b1, len, a, d);
      xfer(1'b0, len, a, d);
   endtask

   // All three masters ask at once; grants must rotate 1, 2, 3.
   task arb_all();
      logic [2:0] exp;
      int w;
      @(posedge pciClk);
      #1 extReq = 3'h7;
      for (int k = 0; k < 3; k++)
      begin
         exp = 3'h1 << k;
         w = 0;
         while (extGrant !== exp && w < 100)
         begin
            @(posedge pciClk);
            #1 w++;
         end
         cmp_grant(extGrant, exp);
         cmp_grant(~{pci_link_if_i.grant_out_3_n, pci_link_if_i.grant_out_2_n,
            pci_link_if_i.grant_out_1_n}, exp);
         if (w >= 100)
            complete_run();
         extReq = extReq & ~exp;
      end
   endtask

   // ****************************************
   // Result watcher and main sequence
   // ****************************************
   // Each finished transfer takes the oldest note; reads compare data.
   always @(posedge clk_sys)
   begin
      if (xferDone === 1'b1)
      begin
         if (noteQ.size() == 0)
            fail("transfer finished unasked");
         else
         begin
            curNote = noteQ.pop_front();
            if (curNote.isRead)
               cmp_burst(xferRdData, curNote.data, curNote.len);
         end
      end
   end

   // Host run, strap flip after reset, then a guest run after a new reset.
   initial
   begin
      do_reset(1'b1);
      for (int n = 0; n < BURST_MAX; n++)
         rw_pair(LEN_W'(n));
      $display("Host transfers finished");
      hostModeStrap = 1'b0;
      arb_all();
      $display("Host arbitration finished");
      do_reset(1'b0);
      extReq = 3'(rand32());
      rw_pair(2'h3);
      rw_pair(2'h1);
      cmp_grant(extGrant, 3'h0);
      cmp_grant({pci_link_if_i.grant_out_3_n, pci_link_if_i.grant_out_2_n,
         pci_link_if_i.grant_out_1_n}, 3'h7);
      // Let the watcher take the last completion before the verdict.
      repeat (2) @(posedge clk_sys);
      #1;
      if (noteQ.size() != 0)
         fail("transfer never completed");
      $display("Guest run finished");
      complete_run();
   end
endmodule // pci_arbitration_pin_interface_tb_top
